// ---- hw/led_pulse_slot_config.sv ----
// Register set and two slot pulse trains for the LED drivers
// Assumes a serial bus bridge giving word accesses on CLK, 7-bit address
`include "led_pulse_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module led_pulse_slot_config (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic [6:0] ADDR,
  input wire logic WR_EN,
  input wire logic [15:0] WR_DATA,
  input wire logic RD_EN,
  output logic [15:0] RD_DATA,
  input wire logic SLOT_A_START,
  input wire logic SLOT_B_START,
  output logic EMITTER_OUTPUT_ONE,
  output logic EMITTER_OUTPUT_TWO,
  output logic EMITTER_OUTPUT_THREE,
  output logic [4:0] FIRST_DRIVER_TRIM,
  output logic [4:0] SECOND_DRIVER_TRIM,
  output logic [4:0] THIRD_DRIVER_TRIM,
  output logic CATHODE_HIGH_BIAS,
  output logic [5:0] CHANNEL_SLEEP_SELECT,
  output logic SLOT_A_BUSY,
  output logic SLOT_B_BUSY
);
  logic [15:0] trim_r, trim_nxt;
  logic [15:0] a_shape_r, a_shape_nxt;
  logic [15:0] a_train_r, a_train_nxt;
  logic [15:0] mask_r, mask_nxt;
  logic [15:0] b_shape_r, b_shape_nxt;
  logic [15:0] b_train_r, b_train_nxt;
  logic [15:0] afe_r, afe_nxt;
  logic [15:0] rd_r, rd_nxt;
  logic tick;
  logic a_pulse, b_pulse, a_busy, b_busy;

  // Address match helper, used by write and read decode
  function automatic logic hit(input logic [6:0] a, input logic [6:0] ofs);
    hit = (a == ofs);
  endfunction

  // True for any of the seven mapped register offsets
  function automatic logic mapped(input logic [6:0] a);
    mapped = hit(a, `OFS_TRIM) || hit(a, `OFS_A_SHAPE) || hit(a, `OFS_A_TRAIN) ||
      hit(a, `OFS_MASK) || hit(a, `OFS_B_SHAPE) || hit(a, `OFS_B_TRAIN) ||
      hit(a, `OFS_AFE);
  endfunction

  // Register writes keep all bits, reserved included
  always_comb begin
    trim_nxt = trim_r;
    a_shape_nxt = a_shape_r;
    a_train_nxt = a_train_r;
    mask_nxt = mask_r;
    b_shape_nxt = b_shape_r;
    b_train_nxt = b_train_r;
    afe_nxt = afe_r;
    if (WR_EN) begin
      if (hit(ADDR, `OFS_TRIM)) trim_nxt = WR_DATA;
      if (hit(ADDR, `OFS_A_SHAPE)) a_shape_nxt = WR_DATA;
      if (hit(ADDR, `OFS_A_TRAIN)) a_train_nxt = WR_DATA;
      if (hit(ADDR, `OFS_MASK)) mask_nxt = WR_DATA;
      if (hit(ADDR, `OFS_B_SHAPE)) b_shape_nxt = WR_DATA;
      if (hit(ADDR, `OFS_B_TRAIN)) b_train_nxt = WR_DATA;
      if (hit(ADDR, `OFS_AFE)) afe_nxt = WR_DATA;
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    rd_nxt = rd_r;
    if (RD_EN) begin
      rd_nxt = 16'h0000;
      if (hit(ADDR, `OFS_TRIM)) rd_nxt = trim_r;
      if (hit(ADDR, `OFS_A_SHAPE)) rd_nxt = a_shape_r;
      if (hit(ADDR, `OFS_A_TRAIN)) rd_nxt = a_train_r;
      if (hit(ADDR, `OFS_MASK)) rd_nxt = mask_r;
      if (hit(ADDR, `OFS_B_SHAPE)) rd_nxt = b_shape_r;
      if (hit(ADDR, `OFS_B_TRAIN)) rd_nxt = b_train_r;
      if (hit(ADDR, `OFS_AFE)) rd_nxt = afe_r;
    end
  end

  // Register file and read data flops
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      trim_r <= `RST_TRIM;
      a_shape_r <= `RST_SHAPE;
      a_train_r <= `RST_TRAIN;
      mask_r <= `RST_MASK;
      b_shape_r <= `RST_SHAPE;
      b_train_r <= `RST_TRAIN;
      afe_r <= `RST_AFE;
      rd_r <= 16'h0000;
    end else begin
      trim_r <= trim_nxt;
      a_shape_r <= a_shape_nxt;
      a_train_r <= a_train_nxt;
      mask_r <= mask_nxt;
      b_shape_r <= b_shape_nxt;
      b_train_r <= b_train_nxt;
      afe_r <= afe_nxt;
      rd_r <= rd_nxt;
    end
  end
  assign RD_DATA = rd_r;

  // Trim codes go out as the driver multiplier codes
  assign FIRST_DRIVER_TRIM = trim_r[`TRIM1_HI:`TRIM1_LO];
  assign SECOND_DRIVER_TRIM = trim_r[`TRIM2_HI:`TRIM2_LO];
  assign THIRD_DRIVER_TRIM = trim_r[`TRIM3_HI:`TRIM3_LO];
  // Bias and power-down selects
  assign CATHODE_HIGH_BIAS = afe_r[`CATH_BIT];
  assign CHANNEL_SLEEP_SELECT = afe_r[`SLEEP_HI:`SLEEP_LO];

  us_tick u_tick (
    .clk(CLK),
    .rstn(RSTN),
    .tick(tick)
  );

  // Slot A train; mute gates pulses only
  pulse_train u_slot_a (
    .clk(CLK),
    .rstn(RSTN),
    .tick(tick),
    .start(SLOT_A_START),
    .mute(mask_r[`MUTE_A_BIT]),
    .first_delay(a_shape_r[`DLY_HI:`DLY_LO]),
    .pulse_len(a_shape_r[`LEN_HI:`LEN_LO]),
    .pulse_total(a_train_r[`TOT_HI:`TOT_LO]),
    .pulse_spacing(a_train_r[`SPC_HI:`SPC_LO]),
    .pulse(a_pulse),
    .busy(a_busy)
  );

  // Slot B train with its own fields
  pulse_train u_slot_b (
    .clk(CLK),
    .rstn(RSTN),
    .tick(tick),
    .start(SLOT_B_START),
    .mute(mask_r[`MUTE_B_BIT]),
    .first_delay(b_shape_r[`DLY_HI:`DLY_LO]),
    .pulse_len(b_shape_r[`LEN_HI:`LEN_LO]),
    .pulse_total(b_train_r[`TOT_HI:`TOT_LO]),
    .pulse_spacing(b_train_r[`SPC_HI:`SPC_LO]),
    .pulse(b_pulse),
    .busy(b_busy)
  );

  // Slot A drives the first emitter, slot B the second; third stays idle
  assign EMITTER_OUTPUT_ONE = a_pulse;
  assign EMITTER_OUTPUT_TWO = b_pulse;
  assign EMITTER_OUTPUT_THREE = 1'b0;
  assign SLOT_A_BUSY = a_busy;
  assign SLOT_B_BUSY = b_busy;

  a_trim_write: assert property (@(posedge CLK) disable iff (!RSTN)
    WR_EN && ADDR == `OFS_TRIM |=> FIRST_DRIVER_TRIM == $past(WR_DATA[4:0]))
    else $error("trim not updated");
  a_mute_a: assert property (@(posedge CLK) disable iff (!RSTN)
    mask_r[`MUTE_A_BIT] && $past(mask_r[`MUTE_A_BIT]) |-> !EMITTER_OUTPUT_ONE)
    else $error("slot A pulsed while muted");
  a_mute_b: assert property (@(posedge CLK) disable iff (!RSTN)
    mask_r[`MUTE_B_BIT] && $past(mask_r[`MUTE_B_BIT]) |-> !EMITTER_OUTPUT_TWO)
    else $error("slot B pulsed while muted");
  a_cath_sel: assert property (@(posedge CLK) disable iff (!RSTN)
    WR_EN && ADDR == `OFS_AFE |=> CATHODE_HIGH_BIAS == $past(WR_DATA[9]))
    else $error("bias select wrong");
  a_sleep_sel: assert property (@(posedge CLK) disable iff (!RSTN)
    WR_EN && ADDR == `OFS_AFE |=> CHANNEL_SLEEP_SELECT == $past(WR_DATA[8:3]))
    else $error("sleep select wrong");
  a_read_back: assert property (@(posedge CLK) disable iff (!RSTN)
    WR_EN && ADDR == `OFS_MASK ##1 RD_EN && !WR_EN && ADDR == `OFS_MASK
    |=> RD_DATA == $past(WR_DATA, 2)) else $error("readback mismatch");
  a_len_bound: assert property (@(posedge CLK) disable iff (!RSTN)
    $rose(EMITTER_OUTPUT_ONE) && a_shape_r[12:8] == 5'h01 && a_train_r[7:0] > 8'h01
    |-> ##[1:26] !EMITTER_OUTPUT_ONE) else $error("slot A pulse too long");
  a_b_timing: assert property (@(posedge CLK) disable iff (!RSTN)
    mask_r[`MUTE_B_BIT] && $rose(b_busy) |-> ##1 b_busy)
    else $error("muted slot B timing stopped");
  c_both: cover property (@(posedge CLK) disable iff (!RSTN) a_busy && b_busy);
  c_read: cover property (@(posedge CLK) disable iff (!RSTN) RD_EN && ADDR == `OFS_AFE);
  c_emit_b: cover property (@(posedge CLK) disable iff (!RSTN) $rose(EMITTER_OUTPUT_TWO));

  // Every trim field follows its write and holds otherwise
  a_trim_second: assert property (@(posedge CLK) disable iff (!RSTN)
    WR_EN && ADDR == `OFS_TRIM |=> SECOND_DRIVER_TRIM == $past(WR_DATA[10:6]))
    else $error("second trim not updated");
  a_trim_third: assert property (@(posedge CLK) disable iff (!RSTN)
    WR_EN && ADDR == `OFS_TRIM |=> THIRD_DRIVER_TRIM == $past(WR_DATA[15:11]))
    else $error("third trim not updated");
  a_trim_hold: assert property (@(posedge CLK) disable iff (!RSTN)
    !(WR_EN && ADDR == `OFS_TRIM) |=> $stable(trim_r))
    else $error("trim changed without write");

  // Slot, mask and global registers take the whole written word; mask and global hold otherwise
  a_ashape_wr: assert property (@(posedge CLK) disable iff (!RSTN)
    WR_EN && ADDR == `OFS_A_SHAPE |=> a_shape_r == $past(WR_DATA))
    else $error("slot A shape not written");
  a_atrain_wr: assert property (@(posedge CLK) disable iff (!RSTN)
    WR_EN && ADDR == `OFS_A_TRAIN |=> a_train_r == $past(WR_DATA))
    else $error("slot A train not written");
  a_bshape_wr: assert property (@(posedge CLK) disable iff (!RSTN)
    WR_EN && ADDR == `OFS_B_SHAPE |=> b_shape_r == $past(WR_DATA))
    else $error("slot B shape not written");
  a_btrain_wr: assert property (@(posedge CLK) disable iff (!RSTN)
    WR_EN && ADDR == `OFS_B_TRAIN |=> b_train_r == $past(WR_DATA))
    else $error("slot B train not written");
  a_mask_wr: assert property (@(posedge CLK) disable iff (!RSTN)
    WR_EN && ADDR == `OFS_MASK |=> mask_r == $past(WR_DATA))
    else $error("mask not written");
  a_mask_hold: assert property (@(posedge CLK) disable iff (!RSTN)
    !(WR_EN && ADDR == `OFS_MASK) |=> $stable(mask_r))
    else $error("mask changed without write");
  a_afe_wr: assert property (@(posedge CLK) disable iff (!RSTN)
    WR_EN && ADDR == `OFS_AFE |=> afe_r == $past(WR_DATA))
    else $error("global config not written");
  a_afe_hold: assert property (@(posedge CLK) disable iff (!RSTN)
    !(WR_EN && ADDR == `OFS_AFE) |=> $stable(afe_r))
    else $error("global config changed without write");

  // Reads return the register as it stood when the strobe was taken
  a_rd_trim: assert property (@(posedge CLK) disable iff (!RSTN)
    RD_EN && ADDR == `OFS_TRIM |=> RD_DATA == $past(trim_r))
    else $error("trim read wrong");
  a_rd_ashape: assert property (@(posedge CLK) disable iff (!RSTN)
    RD_EN && ADDR == `OFS_A_SHAPE |=> RD_DATA == $past(a_shape_r))
    else $error("slot A shape read wrong");
  a_rd_atrain: assert property (@(posedge CLK) disable iff (!RSTN)
    RD_EN && ADDR == `OFS_A_TRAIN |=> RD_DATA == $past(a_train_r))
    else $error("slot A train read wrong");
  a_rd_mask: assert property (@(posedge CLK) disable iff (!RSTN)
    RD_EN && ADDR == `OFS_MASK |=> RD_DATA == $past(mask_r))
    else $error("mask read wrong");
  a_rd_bshape: assert property (@(posedge CLK) disable iff (!RSTN)
    RD_EN && ADDR == `OFS_B_SHAPE |=> RD_DATA == $past(b_shape_r))
    else $error("slot B shape read wrong");
  a_rd_btrain: assert property (@(posedge CLK) disable iff (!RSTN)
    RD_EN && ADDR == `OFS_B_TRAIN |=> RD_DATA == $past(b_train_r))
    else $error("slot B train read wrong");
  a_rd_afe: assert property (@(posedge CLK) disable iff (!RSTN)
    RD_EN && ADDR == `OFS_AFE |=> RD_DATA == $past(afe_r))
    else $error("global config read wrong");
  a_rd_unmapped: assert property (@(posedge CLK) disable iff (!RSTN)
    RD_EN && !mapped(ADDR) |=> RD_DATA == 16'h0000)
    else $error("unmapped read not zero");
  a_rd_hold: assert property (@(posedge CLK) disable iff (!RSTN)
    !RD_EN |=> $stable(RD_DATA))
    else $error("read data moved without strobe");

  // A start is taken only when idle with a nonzero count
  a_start_a: assert property (@(posedge CLK) disable iff (!RSTN)
    SLOT_A_START && !a_busy && a_train_r[`TOT_HI:`TOT_LO] != 8'h00 |=> a_busy)
    else $error("slot A start lost");
  a_zero_a: assert property (@(posedge CLK) disable iff (!RSTN)
    SLOT_A_START && !a_busy && a_train_r[`TOT_HI:`TOT_LO] == 8'h00 |=> !a_busy)
    else $error("slot A started with zero count");
  a_start_b: assert property (@(posedge CLK) disable iff (!RSTN)
    SLOT_B_START && !b_busy && b_train_r[`TOT_HI:`TOT_LO] != 8'h00 |=> b_busy)
    else $error("slot B start lost");
  a_zero_b: assert property (@(posedge CLK) disable iff (!RSTN)
    SLOT_B_START && !b_busy && b_train_r[`TOT_HI:`TOT_LO] == 8'h00 |=> !b_busy)
    else $error("slot B started with zero count");

  // Emitters stay dark outside their train; muted slot A keeps timing
  a_idle_one: assert property (@(posedge CLK) disable iff (!RSTN)
    !a_busy |-> !EMITTER_OUTPUT_ONE)
    else $error("emitter one lit while idle");
  a_idle_two: assert property (@(posedge CLK) disable iff (!RSTN)
    !b_busy |-> !EMITTER_OUTPUT_TWO)
    else $error("emitter two lit while idle");
  a_a_timing: assert property (@(posedge CLK) disable iff (!RSTN)
    mask_r[`MUTE_A_BIT] && $rose(a_busy) |-> ##1 a_busy)
    else $error("muted slot A timing stopped");
  a_tick_gap: assert property (@(posedge CLK) disable iff (!RSTN)
    tick |=> !tick)
    else $error("microsecond tick too long");
endmodule
`default_nettype wire

// ---- hw/led_pulse_regs.svh ----
// Register offsets, field positions, reset values and timing counts
// Assumes inclusion by bare name from design files under hw/
`ifndef LED_PULSE_REGS_SVH
`define LED_PULSE_REGS_SVH
`define OFS_TRIM 7'h25
`define OFS_A_SHAPE 7'h30
`define OFS_A_TRAIN 7'h31
`define OFS_MASK 7'h34
`define OFS_B_SHAPE 7'h35
`define OFS_B_TRAIN 7'h36
`define OFS_AFE 7'h3C
`define RST_TRIM 16'h630C
`define RST_SHAPE 16'h0320
`define RST_TRAIN 16'h0818
`define RST_MASK 16'h0000
`define RST_AFE 16'h3006
`define TRIM3_HI 15
`define TRIM3_LO 11
`define TRIM2_HI 10
`define TRIM2_LO 6
`define TRIM1_HI 4
`define TRIM1_LO 0
`define LEN_HI 12
`define LEN_LO 8
`define DLY_HI 7
`define DLY_LO 0
`define TOT_HI 15
`define TOT_LO 8
`define SPC_HI 7
`define SPC_LO 0
`define MUTE_B_BIT 9
`define MUTE_A_BIT 8
`define CATH_BIT 9
`define SLEEP_HI 8
`define SLEEP_LO 3
`define STEP_NS 1000
`define CLK_NS 40
`define STEP_CYC ((`STEP_NS) / (`CLK_NS))
`endif

// ---- hw/led_pulse_pkg.sv ----
// Types shared by the pulse generator files
// Assumes no other package
package led_pulse_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DELAY = 2'b01,
    ST_HIGH = 2'b11,
    ST_LOW = 2'b10
  } train_state_t;
endpackage

// ---- hw/us_tick.sv ----
// One-cycle tick every microsecond
// Assumes CLK at 25 MHz, synchronous active low reset
`include "led_pulse_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module us_tick (
  input wire logic clk,
  input wire logic rstn,
  output logic tick
);
  logic [4:0] cnt_r;
  logic [4:0] cnt_nxt;
  logic tick_r;
  logic tick_nxt;
  // Divider next value
  always_comb begin
    tick_nxt = 1'b0;
    cnt_nxt = cnt_r + 5'h01;
    if (cnt_r == 5'((`STEP_CYC) - 1)) begin
      cnt_nxt = 5'h00;
      tick_nxt = 1'b1;
    end
  end
  // Divider registers
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cnt_r <= 5'h00;
      tick_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end
  assign tick = tick_r;
endmodule
`default_nettype wire

// ---- hw/pulse_train.sv ----
// One slot pulse train: delay, then count pulses of len at spacing
// Assumes tick is a one-cycle pulse each microsecond on clk
`include "led_pulse_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module pulse_train (
  input wire logic clk,
  input wire logic rstn,
  input wire logic tick,
  input wire logic start,
  input wire logic mute,
  input wire logic [7:0] first_delay,
  input wire logic [4:0] pulse_len,
  input wire logic [7:0] pulse_total,
  input wire logic [7:0] pulse_spacing,
  output logic pulse,
  output logic busy
);
  led_pulse_pkg::train_state_t st_r, st_nxt;
  logic [7:0] us_r, us_nxt;
  logic [7:0] done_r, done_nxt;
  logic pulse_r, pulse_nxt;
  // Sequencer next state; us_r counts microseconds since last event
  always_comb begin
    st_nxt = st_r;
    us_nxt = us_r;
    done_nxt = done_r;
    unique case (st_r)
      led_pulse_pkg::ST_IDLE: begin
        if (start && pulse_total != 8'h00) begin
          st_nxt = led_pulse_pkg::ST_DELAY;
          us_nxt = 8'h00;
          done_nxt = 8'h00;
        end
      end
      led_pulse_pkg::ST_DELAY: begin
        if (us_r == first_delay) begin
          st_nxt = led_pulse_pkg::ST_HIGH;
          us_nxt = 8'h00;
        end else if (tick) begin
          us_nxt = us_r + 8'h01;
        end
      end
      led_pulse_pkg::ST_HIGH, led_pulse_pkg::ST_LOW: begin
        if (tick) begin
          us_nxt = us_r + 8'h01;
          if (us_nxt >= {3'h0, pulse_len}) st_nxt = led_pulse_pkg::ST_LOW;
          if (us_nxt >= pulse_spacing) begin
            us_nxt = 8'h00;
            done_nxt = done_r + 8'h01;
            if (done_nxt == pulse_total) st_nxt = led_pulse_pkg::ST_IDLE;
            else st_nxt = led_pulse_pkg::ST_HIGH;
          end
        end
      end
    endcase
    pulse_nxt = (st_nxt == led_pulse_pkg::ST_HIGH) && !mute;
  end
  // Sequencer registers
  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_r <= led_pulse_pkg::ST_IDLE;
      us_r <= 8'h00;
      done_r <= 8'h00;
      pulse_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      us_r <= us_nxt;
      done_r <= done_nxt;
      pulse_r <= pulse_nxt;
    end
  end
  assign pulse = pulse_r;
  assign busy = st_r != led_pulse_pkg::ST_IDLE;

  a_mute_silent: assert property (@(posedge clk) disable iff (!rstn)
    mute |=> !pulse_r) else $error("pulse while muted");
  a_idle_quiet: assert property (@(posedge clk) disable iff (!rstn)
    st_r == led_pulse_pkg::ST_IDLE |-> !pulse_r) else $error("pulse while idle");
  a_start_dly: assert property (@(posedge clk) disable iff (!rstn)
    $rose(busy) && first_delay != 8'h00 |-> !pulse_r) else $error("early pulse");
  c_train: cover property (@(posedge clk) disable iff (!rstn) $fell(busy));
  c_pulse: cover property (@(posedge clk) disable iff (!rstn) $rose(pulse_r));
endmodule
`default_nettype wire

// ---- sim/led_sink_model.sv ----
// Behavioural LED driver: watches one emitter pin and measures its pulses
// Assumes the pin is a registered level on clk; clr restarts the counts
`timescale 1ns/1ns
`default_nettype none
module led_sink_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic pulse,
  input wire logic clr,
  input wire logic [4:0] trim,
  output int rises,
  output int hi_cyc,
  output int gap_cyc,
  output int first_cyc,
  output int mult_milli
);
  int run;
  int since_rise;
  int since_clr;
  logic prev;
  // Current multiplier in thousandths for the trim code
  assign mult_milli = 710 + 24 * int'(trim);
  // Pulse count, last width, start spacing and first delay in cycles
  always @(posedge clk) begin
    if (!rstn || clr) begin
      rises <= 0;
      run <= 0;
      since_rise <= 0;
      since_clr <= 0;
      prev <= 1'b0;
    end else begin
      prev <= pulse;
      since_clr <= since_clr + 1;
      since_rise <= since_rise + 1;
      run <= pulse ? run + 1 : 0;
      if (!pulse && prev) hi_cyc <= run;
      if (pulse && !prev) begin
        rises <= rises + 1;
        since_rise <= 1;
        if (rises == 0) first_cyc <= since_clr;
        else gap_cyc <= since_rise;
      end
    end
  end
endmodule
`default_nettype wire

// ---- sim/led_pulse_slot_config_test.sv ----
// Self-checking bench for the LED pulse and slot register block
// Assumes the word register port and slot start inputs as in the notes
`timescale 1ns/1ns
`default_nettype none
module led_pulse_slot_config_test;
  logic CLK = 1'b0, RSTN = 1'b0, WR_EN = 1'b0, RD_EN = 1'b0, clr = 1'b0;
  logic SLOT_A_START = 1'b0, SLOT_B_START = 1'b0;
  logic [6:0] ADDR = 7'h00;
  logic [15:0] WR_DATA = 16'h0000;
  logic [15:0] RD_DATA;
  logic EMITTER_OUTPUT_ONE, EMITTER_OUTPUT_TWO, CATHODE_HIGH_BIAS, SLOT_A_BUSY, SLOT_B_BUSY;
  logic [4:0] FIRST_DRIVER_TRIM, SECOND_DRIVER_TRIM, THIRD_DRIVER_TRIM;
  logic [5:0] CHANNEL_SLEEP_SELECT;
  int ra, ha, ga, fa, rb, hb, gb, fb, mult, errors = 0, compares = 0;
  logic [6:0] ofs_tab [7] = '{7'h25, 7'h30, 7'h31, 7'h34, 7'h35, 7'h36, 7'h3C};
  logic [15:0] def_tab [7] = '{16'h630C, 16'h0320, 16'h0818, 16'h0000, 16'h0320,
    16'h0818, 16'h3006};
  // Clock of 40 ns period
  always #20 CLK = ~CLK;
  led_pulse_slot_config dut_u (.CLK(CLK), .RSTN(RSTN), .ADDR(ADDR), .WR_EN(WR_EN),
    .WR_DATA(WR_DATA), .RD_EN(RD_EN), .RD_DATA(RD_DATA), .SLOT_A_START(SLOT_A_START),
    .SLOT_B_START(SLOT_B_START), .EMITTER_OUTPUT_ONE(EMITTER_OUTPUT_ONE),
    .EMITTER_OUTPUT_TWO(EMITTER_OUTPUT_TWO), .EMITTER_OUTPUT_THREE(),
    .FIRST_DRIVER_TRIM(FIRST_DRIVER_TRIM), .SECOND_DRIVER_TRIM(SECOND_DRIVER_TRIM),
    .THIRD_DRIVER_TRIM(THIRD_DRIVER_TRIM), .CATHODE_HIGH_BIAS(CATHODE_HIGH_BIAS),
    .CHANNEL_SLEEP_SELECT(CHANNEL_SLEEP_SELECT), .SLOT_A_BUSY(SLOT_A_BUSY),
    .SLOT_B_BUSY(SLOT_B_BUSY));
  // Far-side drivers for emitter pins one and two; pin three is left unconnected
  led_sink_model sink_a (.clk(CLK), .rstn(RSTN), .pulse(EMITTER_OUTPUT_ONE), .clr(clr),
    .trim(FIRST_DRIVER_TRIM), .rises(ra), .hi_cyc(ha), .gap_cyc(ga), .first_cyc(fa),
    .mult_milli(mult));
  led_sink_model sink_b (.clk(CLK), .rstn(RSTN), .pulse(EMITTER_OUTPUT_TWO), .clr(clr),
    .trim(SECOND_DRIVER_TRIM), .rises(rb), .hi_cyc(hb), .gap_cyc(gb), .first_cyc(fb),
    .mult_milli());
  task stop_test;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task near(input int got, input int exp, input int tol);
    compares++;
    if (got < exp - tol || got > exp + tol) begin
      errors++;
      $display("[ERR] %0t cycles %0d expected %0d", $time, got, exp);
    end
  endtask
  // One-cycle write and read strobes, changed at the falling edge
  task wr(input logic [6:0] a, input logic [15:0] d);
    @(negedge CLK);
    ADDR = a;
    WR_DATA = d;
    WR_EN = 1'b1;
    @(negedge CLK);
    WR_EN = 1'b0;
  endtask
  task rd(input logic [6:0] a, input logic [15:0] exp);
    @(negedge CLK);
    ADDR = a;
    RD_EN = 1'b1;
    @(negedge CLK);
    RD_EN = 1'b0;
    @(negedge CLK);
    chk(RD_DATA, exp);
  endtask
  task test_defaults;
    for (int i = 0; i < 7; i++) rd(ofs_tab[i], def_tab[i]);
    chk({1'b0, FIRST_DRIVER_TRIM, SECOND_DRIVER_TRIM, THIRD_DRIVER_TRIM}, 16'h318C);
    chk({9'h0, CATHODE_HIGH_BIAS, CHANNEL_SLEEP_SELECT}, 16'h0000);
    near(mult, 998, 0);
    $display("test defaults done");
  endtask
  task test_write;
    for (int i = 0; i < 7; i++) wr(ofs_tab[i], 16'hA5C3 ^ {9'h0, ofs_tab[i]});
    for (int i = 0; i < 7; i++) rd(ofs_tab[i], 16'hA5C3 ^ {9'h0, ofs_tab[i]});
    wr(7'h40, 16'hFFFF);
    rd(7'h40, 16'h0000);
    wr(7'h25, 16'hF83F);
    chk({1'b0, FIRST_DRIVER_TRIM, SECOND_DRIVER_TRIM, THIRD_DRIVER_TRIM}, 16'h7C1F);
    wr(7'h3C, 16'h33C6);
    chk({9'h0, CATHODE_HIGH_BIAS, CHANNEL_SLEEP_SELECT}, 16'h0078);
    wr(7'h3C, 16'h3006);
    chk({9'h0, CATHODE_HIGH_BIAS, CHANNEL_SLEEP_SELECT}, 16'h0000);
    // Write, then read the same word in the very next cycle
    @(negedge CLK);
    ADDR = 7'h34;
    WR_DATA = 16'h0300;
    WR_EN = 1'b1;
    @(negedge CLK);
    WR_EN = 1'b0;
    RD_EN = 1'b1;
    @(negedge CLK);
    RD_EN = 1'b0;
    @(negedge CLK);
    chk(RD_DATA, 16'h0300);
    $display("test write done");
  endtask
  // Width 3 us, delay 2 us, then a train of tot pulses at spc us
  task run_slot(input logic b, input logic [7:0] tot, input logic [7:0] spc, input logic mute);
    int n;
    wr(b ? 7'h35 : 7'h30, 16'h0302);
    wr(b ? 7'h36 : 7'h31, {tot, spc});
    wr(7'h34, {6'h00, mute & b, mute & ~b, 8'h00});
    @(negedge CLK);
    clr = 1'b1;
    SLOT_A_START = ~b;
    SLOT_B_START = b;
    @(negedge CLK);
    clr = 1'b0;
    SLOT_A_START = 1'b0;
    SLOT_B_START = 1'b0;
    chk({15'h0, b ? SLOT_B_BUSY : SLOT_A_BUSY}, 16'h0001);
    n = 0;
    while ((b ? SLOT_B_BUSY : SLOT_A_BUSY) !== 1'b0 && n < 2000) begin
      @(negedge CLK);
      n++;
    end
    if (n >= 2000) begin
      errors++;
      $display("[ERR] %0t slot never went idle", $time);
      stop_test;
    end
    near(n, (2 + tot * spc) * 25, 60);
    repeat (4) @(negedge CLK);
    near(b ? rb : ra, mute ? 0 : int'(tot), 0);
    near(b ? ra : rb, 0, 0);
    if (!mute) begin
      near(b ? hb : ha, 75, 24);
      near(b ? gb : ga, int'(spc) * 25, 24);
      near(b ? fb : fa, 50, 28);
    end
    $display("test slot %0d mute %0d done", b, mute);
  endtask
  // Main sequence
  initial begin
    repeat (12) @(negedge CLK);
    RSTN = 1'b1;
    test_defaults;
    test_write;
    run_slot(1'b0, 8'h03, 8'h06, 1'b0);
    run_slot(1'b1, 8'h02, 8'h05, 1'b0);
    // Slots are removed by not starting them; mute only silences pulses
    run_slot(1'b1, 8'h02, 8'h05, 1'b1);
    run_slot(1'b0, 8'h03, 8'h06, 1'b1);
    stop_test;
  end
endmodule
`default_nettype wire
